/* include/irq_collector_regs.vh */
`ifndef IRQ_COLLECTOR_REGS_VH
`define IRQ_COLLECTOR_REGS_VH

// word byte addresses on the wishbone bus
`define IRQC_PORT_A_FLAGS_ADDR 6'h00
`define IRQC_TIMER_FLAGS_ADDR 6'h04
`define IRQC_PERIPH_FLAGS_ADDR 6'h08
`define IRQC_PORT_A_MASKS_ADDR 6'h0c
`define IRQC_TIMER_MASKS_ADDR 6'h10
`define IRQC_PERIPH_MASKS_ADDR 6'h14
`define IRQC_SYS_CTRL_ADDR 6'h18

// system control one fields
`define IRQC_GLOBAL_INT_ENABLE_BIT 0

// field positions in the second flag register
`define IRQC_ONE_HERTZ_BIT 3
`define IRQC_FAST_TICK_BIT 2
`define IRQC_BLINK_TICK_BIT 1
`define IRQC_MELODY_TIMER_BIT 0

// field positions in the third flag register
`define IRQC_SERIAL_BIT 3
`define IRQC_MILLISECOND_BIT 2
`define IRQC_COUNTER_ZERO_BIT 1
`define IRQC_COUNTER_COMPARE_BIT 0

// reset values
`define IRQC_FLAGS_RESET 4'h0
`define IRQC_MASKS_RESET 4'h0
`define IRQC_SYS_CTRL_RESET 4'h0

`endif

/* hw/maskable_irq_collector.v */
`timescale 1ns/1ps
`include "irq_collector_regs.vh"

// Notes on behaviour
// R01: twelve request inputs, each with its own mask bit.
// R02: interrupt out only while a flag is set and global enable is one.
// R03: flag sets only on a rising request edge while its mask is one.
// R04: any reset clears all masks and the global enable.
// R05: reading a flag register returns it, then clears that whole register.
// R06: writing one to a flag bit clears it; zero bits stay.
// R07: software keeps a copy of a read flag register; reads clear it.
// R08: no hardware priority among sources; software picks order.
// R09: masked-off requests are dropped; unmasked ones store regardless of enable.
// R10: requests stored during service stay pending and reassert the interrupt.
// R11: entering halt forces the global enable to one.
// R12: first flag register holds port A pins 3..0 in bits 3..0.
// R13: second register: one hertz, fast tick, blink, melody timer, bits 3..0.
// R14: third register: serial, millisecond, counter zero, counter compare, bits 3..0.
// R15: mask registers mirror flag layout, read and write, reset to zero.
// R16: a new edge coinciding with a clear keeps the flag set.
module maskable_irq_collector (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // request sources, from logic on the same clock
    input wire [3:0] port_pin_request_i,
    input wire one_hertz_request_i,
    input wire fast_tick_request_i,
    input wire blink_tick_request_i,
    input wire melody_timer_request_i,
    input wire serial_request_i,
    input wire millisecond_counter_request_i,
    input wire counter_zero_request_i,
    input wire counter_compare_request_i,
    // cpu side
    input wire halt_enter_i,
    output reg cpu_irq_o
);

    reg [3:0] port_a_request_flags;
    reg [3:0] timer_request_flags;
    reg [3:0] peripheral_request_flags;
    reg [3:0] port_a_request_masks;
    reg [3:0] timer_request_masks;
    reg [3:0] peripheral_request_masks;
    reg global_int_enable;
    reg [11:0] request_prev;
    reg [11:0] next_flags;
    reg [11:0] clear_flags;
    reg [31:0] next_dat;

    wire [11:0] request_now;
    wire [11:0] request_mask_bit;
    wire [11:0] request_flag;
    wire [11:0] edge_hit;
    wire access;
    wire wr;
    wire rd;
    wire lane0;

    // pack the sources into flag register order
    assign request_now[3:0] = port_pin_request_i; // R12
    assign request_now[4 + `IRQC_ONE_HERTZ_BIT] = one_hertz_request_i; // R13
    assign request_now[4 + `IRQC_FAST_TICK_BIT] = fast_tick_request_i;
    assign request_now[4 + `IRQC_BLINK_TICK_BIT] = blink_tick_request_i;
    assign request_now[4 + `IRQC_MELODY_TIMER_BIT] = melody_timer_request_i;
    assign request_now[8 + `IRQC_SERIAL_BIT] = serial_request_i; // R14
    assign request_now[8 + `IRQC_MILLISECOND_BIT] = millisecond_counter_request_i;
    assign request_now[8 + `IRQC_COUNTER_ZERO_BIT] = counter_zero_request_i;
    assign request_now[8 + `IRQC_COUNTER_COMPARE_BIT] = counter_compare_request_i;

    assign request_mask_bit = {peripheral_request_masks, timer_request_masks, port_a_request_masks}; // R01 R15
    assign request_flag = {peripheral_request_flags, timer_request_flags, port_a_request_flags};

    // global enable plays no part in storing
    assign edge_hit = request_now & ~request_prev & request_mask_bit; // R03 R09

    // ack is held off one cycle after each answer so one access acts once
    assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = access & wb_we_i;
    assign rd = access & ~wb_we_i;
    assign lane0 = wb_sel_i[0];

    always @* begin
        clear_flags = 12'h000;
        if (rd) begin
            // read-to-clear acts on the whole addressed register
            case (wb_adr_i)
                `IRQC_PORT_A_FLAGS_ADDR: clear_flags[3:0] = 4'hf; // R05
                `IRQC_TIMER_FLAGS_ADDR: clear_flags[7:4] = 4'hf;
                `IRQC_PERIPH_FLAGS_ADDR: clear_flags[11:8] = 4'hf;
                default: clear_flags = 12'h000;
            endcase
        end else if (wr && lane0) begin
            case (wb_adr_i)
                `IRQC_PORT_A_FLAGS_ADDR: clear_flags[3:0] = wb_dat_i[3:0]; // R06
                `IRQC_TIMER_FLAGS_ADDR: clear_flags[7:4] = wb_dat_i[3:0];
                `IRQC_PERIPH_FLAGS_ADDR: clear_flags[11:8] = wb_dat_i[3:0];
                default: clear_flags = 12'h000;
            endcase
        end
        // set beats clear so a coincident edge survives
        next_flags = (request_flag & ~clear_flags) | edge_hit; // R16 R10
    end

    always @* begin
        next_dat = 32'h0000_0000;
        case (wb_adr_i)
            `IRQC_PORT_A_FLAGS_ADDR: next_dat[3:0] = port_a_request_flags;
            `IRQC_TIMER_FLAGS_ADDR: next_dat[3:0] = timer_request_flags;
            `IRQC_PERIPH_FLAGS_ADDR: next_dat[3:0] = peripheral_request_flags;
            `IRQC_PORT_A_MASKS_ADDR: next_dat[3:0] = port_a_request_masks;
            `IRQC_TIMER_MASKS_ADDR: next_dat[3:0] = timer_request_masks;
            `IRQC_PERIPH_MASKS_ADDR: next_dat[3:0] = peripheral_request_masks;
            `IRQC_SYS_CTRL_ADDR: next_dat[`IRQC_GLOBAL_INT_ENABLE_BIT] = global_int_enable;
            default: next_dat = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            port_a_request_flags <= `IRQC_FLAGS_RESET;
            timer_request_flags <= `IRQC_FLAGS_RESET;
            peripheral_request_flags <= `IRQC_FLAGS_RESET;
            port_a_request_masks <= `IRQC_MASKS_RESET; // R04
            timer_request_masks <= `IRQC_MASKS_RESET;
            peripheral_request_masks <= `IRQC_MASKS_RESET;
            global_int_enable <= 1'b0; // R04
            request_prev <= 12'hfff;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            cpu_irq_o <= 1'b0;
        end else begin
            // prev starts high so a request already high at reset is no edge
            request_prev <= request_now;
            port_a_request_flags <= next_flags[3:0];
            timer_request_flags <= next_flags[7:4];
            peripheral_request_flags <= next_flags[11:8];
            wb_ack_o <= access;
            if (rd) begin
                wb_dat_o <= next_dat;
            end
            if (wr && lane0) begin
                case (wb_adr_i)
                    `IRQC_PORT_A_MASKS_ADDR: port_a_request_masks <= wb_dat_i[3:0]; // R15
                    `IRQC_TIMER_MASKS_ADDR: timer_request_masks <= wb_dat_i[3:0];
                    `IRQC_PERIPH_MASKS_ADDR: peripheral_request_masks <= wb_dat_i[3:0];
                    default: ;
                endcase
            end
            // halt entry wins over a software write in the same cycle
            if (halt_enter_i) begin
                global_int_enable <= 1'b1; // R11
            end else if (wr && lane0 && wb_adr_i == `IRQC_SYS_CTRL_ADDR) begin
                global_int_enable <= wb_dat_i[`IRQC_GLOBAL_INT_ENABLE_BIT];
            end
            // one line, no priority encoding between sources
            cpu_irq_o <= (|next_flags) & global_int_enable; // R02 R08
        end
    end

endmodule

/* sim/irq_collector_monitor.sv */
`timescale 1ns/1ps
module irq_collector_monitor (
    input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cpu_irq_o,
    input wire [31:0] wb_dat_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !cpu_irq_o && !wb_ack_o && !wb_dat_o)
        else $error("outputs busy after reset");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_ack_caused: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    a_idle_quiet: assert property (!wb_cyc_i |=> !wb_ack_o) else $error("ack while idle");
    a_read_narrow: assert property (wb_ack_o |-> wb_dat_o[31:4] == 28'h0) else $error("high bits set");
    a_dat_held: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i) else $error("data moved");
    a_irq_cleared: assert property ($fell(cpu_irq_o) |-> wb_ack_o || $past(wb_ack_o) || $past(rst_i))
        else $error("irq dropped");
endmodule
bind maskable_irq_collector irq_collector_monitor i_irq_collector_monitor (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_ack_o, .cpu_irq_o, .wb_dat_o);

/* sim/request_source_model.sv */
`timescale 1ns/1ps
module request_source_model (
    input wire clk_i,
    input wire [11:0] pattern_i,
    output reg [11:0] request_o = 12'h0
);
    // sources are same-clock logic, so levels move just after an edge
    always @(posedge clk_i)
        request_o <= pattern_i;
endmodule

/* sim/test_maskable_irq_collector.sv */
`timescale 1ns/1ps
module test_maskable_irq_collector;
    reg clk_i = 0, rst_i = 1, on = 0, we = 0, halt = 0;
    reg [5:0] adr = 6'h0, a;
    reg [3:0] dat = 4'h0;
    reg [11:0] pat = 12'h0;
    reg [31:0] q;
    wire [11:0] rq;
    wire [31:0] dout;
    wire ack, irq;
    integer mismatches = 0, checks_done = 0, ticks = 0, i;
    always #25 clk_i = ~clk_i;
    request_source_model i_request_source_model (.clk_i(clk_i), .pattern_i(pat), .request_o(rq));
    maskable_irq_collector i_maskable_irq_collector (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(on), .wb_stb_i(on),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({28'h0, dat}), .wb_dat_o(dout), .wb_ack_o(ack),
        .port_pin_request_i(rq[3:0]), .melody_timer_request_i(rq[4]), .blink_tick_request_i(rq[5]),
        .fast_tick_request_i(rq[6]), .one_hertz_request_i(rq[7]), .counter_compare_request_i(rq[8]),
        .counter_zero_request_i(rq[9]), .millisecond_counter_request_i(rq[10]), .serial_request_i(rq[11]),
        .halt_enter_i(halt), .cpu_irq_o(irq));
    task summarize;
        if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        checks_done = checks_done + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("Error %0t got %h want %h", $time, g, e);
        end
    endtask
    task wb(input [5:0] ad, input w, input [3:0] d);
        @(posedge clk_i);
        on <= 1'b1;
        we <= w;
        adr <= ad;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = dout;
        on <= 1'b0;
    endtask
    task rd(input [5:0] ad, input [31:0] e);
        wb(ad, 1'b0, 4'h0);
        chk(q, e);
    endtask
    // one edge through the source model, then one more before the edge counts
    task put(input [11:0] v);
        pat <= v;
        repeat (3) @(posedge clk_i);
    endtask
    task irq_is(input e);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    task t_reset;
        for (a = 6'h0; a < 6'h20; a = a + 6'h4) rd(a, 0);
        put(12'hfff);
        rd(6'h0, 0);
        put(12'h0);
    endtask
    task t_masks;
        for (a = 6'hc; a < 6'h18; a = a + 6'h4) begin
            wb(a, 1'b1, 4'hf);
            rd(a, 32'hf);
        end
    endtask
    task t_pos;
        for (i = 0; i < 12; i = i + 1) begin
            put(12'h1 << i);
            rd(6'(i / 4 * 4), 32'h1 << (i % 4));
            rd(6'(i / 4 * 4), 0);
            put(12'h0);
        end
    endtask
    task t_irq;
        put(12'h003);
        irq_is(1'b0);
        halt <= 1'b1;
        @(posedge clk_i);
        halt <= 1'b0;
        irq_is(1'b1);
        wb(6'h0, 1'b1, 4'h1);
        irq_is(1'b1);
        wb(6'h0, 1'b1, 4'h2);
        irq_is(1'b0);
        rd(6'h18, 32'h1);
        put(12'h0);
        put(12'h030);
        irq_is(1'b1);
        rd(6'h4, 32'h3);
        irq_is(1'b0);
    endtask
    always @(posedge clk_i) begin
        ticks <= ticks + 1;
        if (ticks == 2000) begin
            mismatches = mismatches + 1;
            summarize;
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_masks;
        t_pos;
        t_irq;
        summarize;
    end
endmodule
